// ### design/spip_pkg.sv
/*
 * Constants and types of the port policy block.
 * Assumes one 40 MHz clock and a strobe register port.
 */
// How it works
// - Each port holds an ingress limit of 0 to 999 steps of 100 kbit/s, 0 is off.
// - Each port holds an egress limit of 0 to 999 steps of 100 kbit/s, 0 is off.
// - Ingress limits throttle by pause in full or back pressure in half duplex, ports 0 to 23.
// - The flow control switch only acts while the port runs full duplex.
// - The back pressure switch only acts while the port runs half duplex.
// - A disabled port neither receives nor transmits frames.
// - Negotiation is full auto, auto with only the set speed and duplex, or forced.
// - A high priority port marks every received frame high priority.
// - A secure port never learns new source addresses.
// - A secure port forwards only frames with a known source and drops the rest.
// - Static entries stay bound to their port and never age out.
// - In tag VLAN mode static and filter entries also match on VLAN.
// - A frame whose destination matches a filter entry in its VLAN is dropped.
// - Learned entries age out after 300 to 765 idle seconds, 300 by default.
package spip_pkg;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int NUM_PORTS = 26;
    localparam int RATE_PORTS = 24;
    localparam int PORT_W = 5;
    localparam int RATE_W = 10;
    localparam int CLK_HZ = 40_000_000;
    localparam int RATE_UNIT_BPS = 100_000;
    localparam int CREDIT_PER_BIT = CLK_HZ / RATE_UNIT_BPS;
    localparam int BYTE_COST = 8 * CREDIT_PER_BIT;
    localparam logic [RATE_W-1:0] RATE_MAX = 10'd999;
    localparam logic [9:0] AGE_MIN_S = 10'd300;
    localparam logic [9:0] AGE_MAX_S = 10'd765;
    localparam logic [9:0] AGE_RST_S = 10'd300;
    localparam int TICK_1S_CYCLES = CLK_HZ;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [9:0] PORT_CFG_BASE = 10'h000;
    localparam logic [9:0] PORT_STAT_BASE = 10'h080;
    localparam logic [9:0] GLOBAL_CTL = 10'h100;
    localparam logic [9:0] AGE_TIME = 10'h104;
    localparam logic [9:0] TBL_MAC_LO = 10'h108;
    localparam logic [9:0] TBL_MAC_HI = 10'h10c;
    localparam logic [9:0] TBL_CTL = 10'h110;
    localparam int TBL_CMD_BIT = 24;
    localparam int TBL_VALID_BIT = 25;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {NEG_AUTO = 2'b00, NEG_NWAY = 2'b01, NEG_FORCE = 2'b10} spip_neg_e;
    typedef enum logic [1:0] {KIND_DYN = 2'b00, KIND_STATIC = 2'b01, KIND_FILTER = 2'b10} spip_kind_e;
    localparam logic [1:0] SPD_10 = 2'b00;
    localparam logic [1:0] SPD_100 = 2'b01;

    // Port configuration word, msb first
    typedef struct packed {
        logic [1:0] rsv;
        logic [RATE_W-1:0] out_rate;
        logic [RATE_W-1:0] in_rate;
        logic secure;
        logic high_prio;
        logic bp_en;
        logic fc_en;
        logic full;
        logic [1:0] speed;
        spip_neg_e neg;
        logic enable;
    } spip_port_cfg_s;
    localparam logic [31:0] CFG_RST = 32'h0000_0029;

    typedef struct packed {
        spip_neg_e neg;
        logic [1:0] speed;
        logic full;
    } spip_phy_cfg_s;

    typedef struct packed {
        logic valid;
        spip_kind_e kind;
        logic [47:0] mac;
        logic [11:0] vid;
        logic [PORT_W-1:0] port;
        logic [9:0] age;
    } spip_entry_s;

    typedef struct packed {
        logic [PORT_W-1:0] port;
        logic [47:0] frame_source_address;
        logic [47:0] dst_addr;
        logic [11:0] vid;
    } spip_frame_s;

    typedef struct packed {
        logic forward;
        logic high_prio;
        logic drop_disabled;
        logic drop_filter;
        logic drop_secure;
        logic dst_known;
        logic [PORT_W-1:0] dst_port;
    } spip_verdict_s;

endpackage

// ### design/spip_token_bucket.sv
/*
 * Token bucket: the rate refills, bytes spend.
 * Assumes take strobes on the same clock.
 */
`timescale 1ns/100ps
module spip_token_bucket
    import spip_pkg::*;
#(
    parameter int BURST_BYTES = 1536
)
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [RATE_W-1:0] rate_i,
    input wire logic take_i,
    output logic empty_o
);
    localparam logic [31:0] CAP = 32'(BURST_BYTES * BYTE_COST);
    localparam logic [31:0] COST = 32'(BYTE_COST);

    logic [31:0] level;
    wire logic [31:0] filled = level + 32'(rate_i);
    wire logic [31:0] capped = (filled > CAP) ? CAP : filled;
    wire logic [31:0] taken = (take_i && capped >= COST) ? capped - COST : capped;
    // Zero rate parks the bucket full so turning a limit on starts with a burst
    wire logic [31:0] next_level = (rate_i == '0) ? CAP : taken;

    // Bucket state and registered empty flag
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            level <= CAP;
            empty_o <= 1'b0;
        end
        else
        begin
            level <= next_level;
            empty_o <= (next_level < COST);
        end
    end

    if (BURST_BYTES < 1 || BURST_BYTES > 65536)
        $error("BURST_BYTES out of range");
endmodule

// ### design/spip_addr_table.sv
/*
 * Address table: lookups, learning and aging.
 * Assumes one clock.
 */
`timescale 1ns/100ps
module spip_addr_table
    import spip_pkg::*;
#(
    parameter int DEPTH = 16
)
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic vlan_mode_i,
    input wire logic sw_wr_i,
    input wire logic [$clog2(DEPTH)-1:0] sw_idx_i,
    input wire spip_entry_s sw_entry_i,
    input wire logic seen_i,
    input wire spip_frame_s frame_i,
    input wire logic age_tick_i,
    input wire logic age_en_i,
    input wire logic [9:0] age_limit_i,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
    output logic src_known_o,
    output logic dst_filtered_o,
    output logic dst_known_o,
    output logic [PORT_W-1:0] dst_port_o,
    output spip_entry_s rd_entry_o
);
    localparam int IW = $clog2(DEPTH);
    spip_entry_s tbl [DEPTH];
    logic [DEPTH-1:0] src_hit, dst_hit, dst_filt, free;
    logic [IW-1:0] free_idx;
    logic free_any;

    // Address plus VLAN compare, VLAN ignored outside tag mode
    function automatic logic key_match(spip_entry_s e, logic [47:0] mac, logic [11:0] vid,
                                       logic vm);
        return e.valid && e.mac == mac && (!vm || e.vid == vid);
    endfunction

    // Parallel lookups; lowest free slot takes a new address
    always_comb
    begin
        free_idx = '0;
        free_any = 1'b0;
        dst_port_o = '0;
        for (int i = DEPTH - 1; i >= 0; i--)
        begin
            src_hit[i] = key_match(tbl[i], frame_i.frame_source_address, frame_i.vid, vlan_mode_i)
                         && tbl[i].kind != KIND_FILTER;
            dst_hit[i] = key_match(tbl[i], frame_i.dst_addr, frame_i.vid, vlan_mode_i)
                         && tbl[i].kind != KIND_FILTER;
            dst_filt[i] = key_match(tbl[i], frame_i.dst_addr, frame_i.vid, vlan_mode_i)
                          && tbl[i].kind == KIND_FILTER;
            free[i] = !tbl[i].valid;
            if (free[i])
            begin
                free_idx = IW'(i);
                free_any = 1'b1;
            end
            if (dst_hit[i])
                dst_port_o = tbl[i].port;
        end
    end
    assign src_known_o = |src_hit;
    assign dst_known_o = |dst_hit;
    assign dst_filtered_o = |dst_filt;
    assign rd_entry_o = tbl[rd_idx_i];
    // A learn yields to a same-cycle software write
    wire logic learn = seen_i && !src_known_o && free_any && !sw_wr_i;

    // One slot per generate step; software wins, then learn, refresh, age
    for (genvar g = 0; g < DEPTH; g++)
    begin : g_slot
        wire logic dyn = tbl[g].valid && tbl[g].kind == KIND_DYN;
        wire logic [9:0] aged = tbl[g].age + 10'd1;
        always_ff @(posedge clk_sys_i or posedge sys_rst_i)
        begin
            if (sys_rst_i)
                tbl[g] <= '0;
            else if (sw_wr_i && sw_idx_i == IW'(g))
                tbl[g] <= sw_entry_i;
            else if (learn && free_idx == IW'(g))
                tbl[g] <= '{1'b1, KIND_DYN, frame_i.frame_source_address, frame_i.vid,
                            frame_i.port, 10'd0};
            else if (seen_i && src_hit[g] && dyn)
                tbl[g].age <= '0;
            else if (age_tick_i && age_en_i && dyn)
            begin
                if (aged >= age_limit_i)
                    tbl[g].valid <= 1'b0;
                else
                    tbl[g].age <= aged;
            end
        end
    end

    if (DEPTH < 2 || DEPTH > 32)
        $error("DEPTH out of range");
endmodule

// ### design/spip_port_policy.sv
/*
 * Port policy top: port registers,
 * rate limits with pause and back pressure,
 * negotiation and the frame verdict.
 * Assumes requests and byte strobes on this
 * clock; the PHY duplex arrives
 * asynchronously.
 */
`timescale 1ns/100ps
module spip_port_policy
    import spip_pkg::*;
#(
    parameter int N_PORTS = NUM_PORTS,
    parameter int N_RATE_PORTS = RATE_PORTS,
    parameter int TABLE_DEPTH = 16,
    parameter int BURST_BYTES = 1536,
    parameter int TICK_CYCLES = TICK_1S_CYCLES
)
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [9:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Per-port link side
    input wire logic [N_PORTS-1:0] link_full_i,
    input wire logic [N_PORTS-1:0] congest_i,
    input wire logic [N_PORTS-1:0] rx_byte_i,
    input wire logic [N_PORTS-1:0] tx_byte_i,
    output logic [N_PORTS-1:0] port_rx_en_o,
    output logic [N_PORTS-1:0] port_tx_en_o,
    output logic [N_PORTS-1:0] pause_req_o,
    output logic [N_PORTS-1:0] bp_req_o,
    output spip_phy_cfg_s [N_PORTS-1:0] phy_cfg_o,
    // Frame lookup
    input wire logic frame_valid_i,
    input wire spip_frame_s frame_i,
    output logic verdict_valid_o,
    output spip_verdict_s verdict_o
);
    localparam int IW = $clog2(TABLE_DEPTH);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // Per-port window hit
    function automatic logic area_hit(logic [9:0] addr, logic [9:0] base);
        return addr[9:7] == base[9:7] && addr[1:0] == 2'b00
               && 32'(addr[6:2]) < N_PORTS;
    endfunction

    // Rates above the ceiling clamp, not wrap
    function automatic logic [RATE_W-1:0] clamp_rate(logic [RATE_W-1:0] v);
        return (v > RATE_MAX) ? RATE_MAX : v;
    endfunction

    wire logic [PORT_W-1:0] reg_port = reg_addr_i[6:2];
    wire logic cfg_hit = area_hit(reg_addr_i, PORT_CFG_BASE);
    wire logic stat_hit = area_hit(reg_addr_i, PORT_STAT_BASE);
    wire logic glob_hit = reg_addr_i == GLOBAL_CTL;
    wire logic age_hit = reg_addr_i == AGE_TIME;
    wire logic mlo_hit = reg_addr_i == TBL_MAC_LO;
    wire logic mhi_hit = reg_addr_i == TBL_MAC_HI;
    wire logic tctl_hit = reg_addr_i == TBL_CTL;

    // ------------------------------------------------------------
    // Global registers
    // ------------------------------------------------------------
    logic vlan_mode;
    logic age_en;
    logic [9:0] age_time;
    logic [47:0] stage_mac;
    logic [11:0] stage_vid;
    logic [IW-1:0] tbl_idx;
    logic [31:0] tick_cnt;
    logic age_tick;

    // Aging time clamps to its window
    wire logic [9:0] wr_age = reg_wdata_i[9:0];
    wire logic [9:0] next_age_time = (wr_age < AGE_MIN_S) ? AGE_MIN_S :
                                     (wr_age > AGE_MAX_S) ? AGE_MAX_S : wr_age;
    wire logic tbl_cmd = reg_wr_i && tctl_hit && reg_wdata_i[TBL_CMD_BIT];
    spip_entry_s sw_entry;
    assign sw_entry = '{reg_wdata_i[TBL_VALID_BIT], spip_kind_e'(reg_wdata_i[6:5]), stage_mac,
                        stage_vid, reg_wdata_i[11:7], 10'd0};

    // Control, aging time and table staging
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            vlan_mode <= 1'b0;
            age_en <= 1'b1;
            age_time <= AGE_RST_S;
            stage_mac <= '0;
            stage_vid <= '0;
            tbl_idx <= '0;
        end
        else if (reg_wr_i)
        begin
            if (glob_hit)
            begin
                vlan_mode <= reg_wdata_i[0];
                age_en <= reg_wdata_i[1];
            end
            if (age_hit)
                age_time <= next_age_time;
            if (mlo_hit)
                stage_mac[31:0] <= reg_wdata_i;
            if (mhi_hit)
            begin
                stage_mac[47:32] <= reg_wdata_i[15:0];
                stage_vid <= reg_wdata_i[27:16];
            end
            if (tctl_hit)
                tbl_idx <= reg_wdata_i[IW-1:0];
        end
    end

    // Aging tick; its period is a parameter
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            tick_cnt <= '0;
            age_tick <= 1'b0;
        end
        else
        begin
            age_tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 32'd1;
        end
    end

    // ------------------------------------------------------------
    // Per-port configuration, rate control and throttling
    // ------------------------------------------------------------
    spip_port_cfg_s cfg [N_PORTS];
    logic [31:0] stat_word [N_PORTS];

    for (genvar p = 0; p < N_PORTS; p++)
    begin : g_port
        spip_port_cfg_s wcfg;
        spip_port_cfg_s next_cfg;
        logic full_meta, full_sync;
        logic in_empty, out_empty;
        wire logic cfg_wr = reg_wr_i && cfg_hit && reg_port == PORT_W'(p);

        // Illegal negotiation code falls back to full auto
        always_comb
        begin
            wcfg = spip_port_cfg_s'(reg_wdata_i);
            next_cfg = wcfg;
            next_cfg.rsv = '0;
            next_cfg.in_rate = clamp_rate(wcfg.in_rate);
            next_cfg.out_rate = clamp_rate(wcfg.out_rate);
            if (reg_wdata_i[2:1] == 2'b11)
                next_cfg.neg = NEG_AUTO;
        end

        always_ff @(posedge clk_sys_i or posedge sys_rst_i)
        begin
            if (sys_rst_i)
                cfg[p] <= spip_port_cfg_s'(CFG_RST);
            else if (cfg_wr)
                cfg[p] <= next_cfg;
        end

        // Duplex comes from the PHY, so it is synchronised
        always_ff @(posedge clk_sys_i or posedge sys_rst_i)
        begin
            if (sys_rst_i)
            begin
                full_meta <= 1'b0;
                full_sync <= 1'b0;
            end
            else
            begin
                full_meta <= link_full_i[p];
                full_sync <= full_meta;
            end
        end

        // Only the first ports carry buckets; the rest throttle only on congestion
        if (p < N_RATE_PORTS)
        begin : g_rate
            spip_token_bucket #(
                .BURST_BYTES(BURST_BYTES)
            ) u_in (
                .clk_sys_i(clk_sys_i),
                .sys_rst_i(sys_rst_i),
                .rate_i(cfg[p].in_rate),
                .take_i(rx_byte_i[p]),
                .empty_o(in_empty)
            );
            spip_token_bucket #(
                .BURST_BYTES(BURST_BYTES)
            ) u_out (
                .clk_sys_i(clk_sys_i),
                .sys_rst_i(sys_rst_i),
                .rate_i(cfg[p].out_rate),
                .take_i(tx_byte_i[p]),
                .empty_o(out_empty)
            );
        end
        else
        begin : g_norate
            assign in_empty = 1'b0;
            assign out_empty = 1'b0;
        end

        // Pause only in full duplex, back pressure only in half duplex
        wire logic next_pause = cfg[p].enable && full_sync
                                && (in_empty || (cfg[p].fc_en && congest_i[p]));
        wire logic next_bp = cfg[p].enable && !full_sync
                             && (in_empty || (cfg[p].bp_en && congest_i[p]));

        always_ff @(posedge clk_sys_i or posedge sys_rst_i)
        begin
            if (sys_rst_i)
            begin
                pause_req_o[p] <= 1'b0;
                bp_req_o[p] <= 1'b0;
                port_rx_en_o[p] <= 1'b0;
                port_tx_en_o[p] <= 1'b0;
            end
            else
            begin
                pause_req_o[p] <= next_pause;
                bp_req_o[p] <= next_bp;
                port_rx_en_o[p] <= cfg[p].enable;
                port_tx_en_o[p] <= cfg[p].enable && !out_empty;
            end
        end

        // Negotiation settings straight from config
        assign phy_cfg_o[p] = '{cfg[p].neg, cfg[p].speed, cfg[p].full};
        assign stat_word[p] = {27'h0, bp_req_o[p], pause_req_o[p], out_empty, in_empty,
                               full_sync};
    end

    // ------------------------------------------------------------
    // Frame verdict
    // ------------------------------------------------------------
    logic src_known, dst_filtered, dst_known;
    logic [PORT_W-1:0] dst_port;
    spip_entry_s rd_entry;

    wire logic fport_ok = 32'(frame_i.port) < N_PORTS;
    wire spip_port_cfg_s fcfg = fport_ok ? cfg[frame_i.port] : spip_port_cfg_s'(32'h0);
    // Secure ports never feed the learner
    wire logic seen = frame_valid_i && fcfg.enable && !fcfg.secure;

    spip_addr_table #(
        .DEPTH(TABLE_DEPTH)
    ) u_table (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .vlan_mode_i(vlan_mode),
        .sw_wr_i(tbl_cmd),
        .sw_idx_i(reg_wdata_i[IW-1:0]),
        .sw_entry_i(sw_entry),
        .seen_i(seen),
        .frame_i(frame_i),
        .age_tick_i(age_tick),
        .age_en_i(age_en),
        .age_limit_i(age_time),
        .rd_idx_i(tbl_idx),
        .src_known_o(src_known),
        .dst_filtered_o(dst_filtered),
        .dst_known_o(dst_known),
        .dst_port_o(dst_port),
        .rd_entry_o(rd_entry)
    );

    spip_verdict_s next_verdict;
    // Drop causes apart; forward when none applies
    always_comb
    begin
        next_verdict.drop_disabled = !fcfg.enable;
        next_verdict.drop_filter = dst_filtered;
        next_verdict.drop_secure = fcfg.secure && !src_known;
        next_verdict.high_prio = fcfg.high_prio;
        next_verdict.dst_known = dst_known;
        next_verdict.dst_port = dst_port;
        next_verdict.forward = fcfg.enable && !dst_filtered
                               && !(fcfg.secure && !src_known);
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            verdict_valid_o <= 1'b0;
            verdict_o <= '0;
        end
        else
        begin
            verdict_valid_o <= frame_valid_i;
            if (frame_valid_i)
                verdict_o <= next_verdict;
        end
    end

    // ------------------------------------------------------------
    // Register read back
    // ------------------------------------------------------------
    logic [31:0] next_rdata;
    // Unmapped addresses read as zero
    always_comb
    begin
        next_rdata = '0;
        if (cfg_hit)
            next_rdata = 32'(cfg[reg_port]);
        else if (stat_hit)
            next_rdata = stat_word[reg_port];
        else if (glob_hit)
            next_rdata = {30'h0, age_en, vlan_mode};
        else if (age_hit)
            next_rdata = {22'h0, age_time};
        else if (mlo_hit)
            next_rdata = rd_entry.mac[31:0];
        else if (mhi_hit)
            next_rdata = {4'h0, rd_entry.vid, rd_entry.mac[47:32]};
        else if (tctl_hit)
            next_rdata = {6'h0, rd_entry.valid, 3'h0, rd_entry.age, rd_entry.port,
                          rd_entry.kind, 5'(tbl_idx)};
    end

    // Read data stands one cycle only
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            reg_rdata_o <= '0;
        else
            reg_rdata_o <= reg_rd_i ? next_rdata : 32'h0;
    end

    if (N_RATE_PORTS > N_PORTS || N_PORTS > 32 || N_PORTS < 1)
        $error("Port counts out of range");
    if (TICK_CYCLES < 2)
        $error("TICK_CYCLES too small");
endmodule

// ### testbench/spip_checker.sv
/* Checker: verdict timing and throttle polarity.
   Assumes a bind from the bench top. */
`timescale 1ns/100ps
module spip_checker
    import spip_pkg::*;
#(parameter int N_PORTS = 26)
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic frame_valid_i,
    input wire logic verdict_valid_o,
    input wire spip_verdict_s verdict_o,
    input wire logic [N_PORTS-1:0] link_full_i,
    input wire logic [N_PORTS-1:0] pause_req_o,
    input wire logic [N_PORTS-1:0] bp_req_o
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    wire fwd = verdict_valid_o && verdict_o.forward;
    // Duplex checks once the synchroniser has caught up
    AST_VLD: assert property (frame_valid_i |=> verdict_valid_o)
        else $error("verdict missing");
    AST_VLD_ONE: assert property (!frame_valid_i |=> !verdict_valid_o)
        else $error("verdict without request");
    AST_DIS: assert property (fwd |-> !verdict_o.drop_disabled)
        else $error("disabled port forwarded");
    AST_FLT: assert property (fwd |-> !verdict_o.drop_filter)
        else $error("filtered frame forwarded");
    AST_SEC: assert property (fwd |-> !verdict_o.drop_secure)
        else $error("secure drop forwarded");
    AST_ONE_WAY: assert property ((pause_req_o & bp_req_o) == '0)
        else $error("pause and back pressure");
    AST_FC: assert property ($stable(link_full_i) && $past(link_full_i, 3) == link_full_i
        |-> (pause_req_o & ~link_full_i) == '0)
        else $error("pause on half duplex");
    AST_BP: assert property ($stable(link_full_i) && $past(link_full_i, 3) == link_full_i
        |-> (bp_req_o & link_full_i) == '0)
        else $error("back pressure on full duplex");
endmodule

// ### testbench/spip_partner.sv
/* Link partners: one byte a cycle on each asked port.
   Assumes hold-off on the same clock. */
`timescale 1ns/100ps
module spip_partner (
    input wire logic clk_sys_i,
    input wire logic [25:0] go_i,
    input wire logic [25:0] hold_i,
    output logic [25:0] rx_byte_o
);
    // A partner that ignored hold-off would hide a dead throttle
    always_ff @(posedge clk_sys_i)
        rx_byte_o <= go_i & ~hold_i;
endmodule

// ### testbench/spip_port_policy_tb.sv
/* Bench: verdicts, negotiation, rate, aging, VLAN, reset.
   Assumes spip_partner sends rx bytes. */
`timescale 1ns/100ps
module spip_port_policy_tb;
    import spip_pkg::*;
    logic clk_sys_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, frame_valid_i = 0;
    logic [9:0] reg_addr_i = '0;
    logic [31:0] reg_wdata_i = '0, reg_rdata_o;
    logic [25:0] link_full_i = 26'h1000240, go = '0, tx_byte_i = '0, rx_byte_i, congest_i = '0;
    logic [25:0] port_rx_en_o, port_tx_en_o, pause_req_o, bp_req_o;
    spip_phy_cfg_s [25:0] phy_cfg_o;
    spip_frame_s frame_i = '0;
    logic verdict_valid_o;
    spip_verdict_s verdict_o;
    wire thr = pause_req_o[6] && bp_req_o[7] && !port_tx_en_o[8];
    int bad_count = 0, comparisons = 0, i;
    // Setup writes: port configs, static and filter entries
    logic [41:0] cfg [12] = '{{10'h000, 32'h129}, {10'h004, 32'h229}, {10'h008, 32'h28},
        {10'h018, 32'h429}, {10'h01c, 32'h429}, {10'h060, 32'h429}, {10'h020, 32'h100029},
        {TBL_MAC_HI, 32'h0}, {TBL_MAC_LO, 32'haa}, {TBL_CTL, 32'h30001a0},
        {TBL_MAC_LO, 32'hbb}, {TBL_CTL, 32'h3000041}};
    // Rows: port, source, destination, forward, priority
    logic [22:0] row [9] = '{{5'd0, 8'h11, 8'h22, 2'b11}, {5'd4, 8'h12, 8'h22, 2'b10},
        {5'd1, 8'h33, 8'h22, 2'b00}, {5'd1, 8'haa, 8'h22, 2'b10}, {5'd1, 8'h11, 8'h22, 2'b10},
        {5'd4, 8'h12, 8'hbb, 2'b00}, {5'd2, 8'h12, 8'h22, 2'b00}, {5'd1, 8'h33, 8'h22, 2'b00},
        {5'd26, 8'h12, 8'h22, 2'b00}};
    spip_port_policy #(.BURST_BYTES(2), .TICK_CYCLES(10)) dut (.clk_sys_i, .sys_rst_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .link_full_i, .congest_i,
        .rx_byte_i, .tx_byte_i, .port_rx_en_o, .port_tx_en_o, .pause_req_o, .bp_req_o,
        .phy_cfg_o, .frame_valid_i, .frame_i, .verdict_valid_o, .verdict_o);
    spip_partner lp (.clk_sys_i, .go_i(go), .hold_i(pause_req_o | bp_req_o), .rx_byte_o(rx_byte_i));
    // Clock; egress sends on port 8 while allowed
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) tx_byte_i <= go & port_tx_en_o & 26'h100;
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo(input logic ok);
        chk(ok, 1'b1);
        if (ok !== 1'b1)
            summarize();
    endtask
    // Read data stand one cycle
    task automatic bus(input logic w, logic [9:0] a, logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= w;
        reg_rd_i <= !w;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1;
        if (!w)
            chk(reg_rdata_o, d);
        @(posedge clk_sys_i);
    endtask
    task automatic frm(input logic [4:0] p, logic [7:0] s, d, logic [11:0] v);
        frame_i <= '{p, {40'h0, s}, {40'h0, d}, v};
        frame_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        frame_valid_i <= 1'b0;
        #1;
        chk(verdict_valid_o, 1'b1);
        @(posedge clk_sys_i);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        foreach (cfg[k]) bus(1'b1, cfg[k][41:32], cfg[k][31:0]);
        foreach (row[k])
        begin
            frm(row[k][22:18], row[k][17:10], row[k][9:2], 12'h0);
            chk({verdict_o.forward, verdict_o.high_prio}, row[k][1:0]);
        end
        for (i = 0; i < 3; i++)
        begin
            bus(1'b1, 10'h014, 32'h29 | (i << 1));
            chk(phy_cfg_o[5], {i[1:0], 3'b011});
        end
        $display("table and negotiation done");
        go <= 26'h10003c0;
        for (i = 0; i < 300 && !thr; i++)
            @(posedge clk_sys_i);
        tmo(thr);
        chk({pause_req_o[24], bp_req_o[24], pause_req_o[9]}, 3'b0);
        for (i = 0; i < 5000 && pause_req_o[6]; i++)
            @(posedge clk_sys_i);
        tmo(!pause_req_o[6]);
        go <= '0;
        bus(1'b1, AGE_TIME, 32'h64);
        bus(1'b0, AGE_TIME, 32'h12c);
        bus(1'b1, AGE_TIME, 32'h3e7);
        bus(1'b0, AGE_TIME, 32'h2fd);
        bus(1'b1, AGE_TIME, 32'h12c);
        frm(5'd0, 8'h11, 8'h22, 12'h0);
        repeat (3200) @(posedge clk_sys_i);
        frm(5'd1, 8'h11, 8'h22, 12'h0);
        chk(verdict_o.forward, 1'b0);
        frm(5'd1, 8'haa, 8'h22, 12'h0);
        chk(verdict_o.forward, 1'b1);
        frm(5'd0, 8'h11, 8'haa, 12'h0);
        chk({verdict_o.dst_known, verdict_o.dst_port}, 6'h23);
        bus(1'b1, GLOBAL_CTL, 32'h3);
        frm(5'd4, 8'h12, 8'hbb, 12'h5);
        chk(verdict_o.forward, 1'b1);
        frm(5'd4, 8'h12, 8'hbb, 12'h0);
        chk(verdict_o.forward, 1'b0);
        bus(1'b0, 10'h3fc, 32'h0);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        bus(1'b0, 10'h000, 32'h29);
        chk(port_rx_en_o, 26'h3ffffff);
        summarize();
    end
endmodule
bind spip_port_policy spip_checker #(.N_PORTS(N_PORTS)) u_chk (.clk_sys_i, .sys_rst_i,
    .frame_valid_i, .verdict_valid_o, .verdict_o, .link_full_i, .pause_req_o, .bp_req_o);
